// >>> hdl/profile_and_number_store.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module profile_and_number_store
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // register port
  input  wire pans_pkg::pans_bus_type bus,
  output logic [7:0]                  rdata,
  // terminal characters in and out
  input  wire pans_pkg::pans_char_type rxIn,
  output pans_pkg::pans_char_type     txOut,
  input  wire logic                   txReady,
  // synchronous clock pins
  input  wire logic                   dteTxClk,
  input  wire logic                   carrierClk,
  output logic                        txClkOut
);

  pans_pkg::pans_regs_type r;
  pans_pkg::pans_regs_type next_r;

  // memories: active profile, nonvolatile store, scratch line
  logic [7:0] activeMem  [pans_pkg::PROF_BYTES];
  logic [7:0] storedMem  [2][pans_pkg::PROF_BYTES];
  logic [7:0] numMem     [pans_pkg::NUM_SLOTS][pans_pkg::NUM_CHARS];
  logic [5:0] numLen     [pans_pkg::NUM_SLOTS];
  logic [7:0] scratch    [pans_pkg::NUM_CHARS];
  logic       resetSel;

  // write ports of the memories
  logic       actWe, stoWe, numWe, lenWe, scrWe, rselWe, rselD;
  logic [4:0] actAddr;
  logic [7:0] actData;
  logic [7:0] stoData;
  logic [5:0] scrAddr;
  logic [7:0] scrData;

  // decimal digit of an 8-bit value, place 2 = hundreds
  function automatic logic [7:0] decDigit(input logic [7:0] v,
                                          input logic [1:0] place);
    logic [7:0] d;
    d = 8'(v % 8'd10);
    if (place == 2'd2)
      d = 8'(v / 8'd100);
    else if (place == 2'd1)
      d = 8'((v / 8'd10) % 8'd10);
    return pans_pkg::ASC_0 + d;
  endfunction : decDigit

  // verbose word of a result code, space padded
  function automatic logic [79:0] resWord(input logic [2:0] code);
    logic [79:0] w;
    unique case (code)
      pans_pkg::RC_OK:        w = "OK        ";
      pans_pkg::RC_CONNECT:   w = "CONNECT   ";
      pans_pkg::RC_RING:      w = "RING      ";
      pans_pkg::RC_NOCARRIER: w = "NO CARRIER";
      pans_pkg::RC_ERROR:     w = "ERROR     ";
      default:                w = "          ";
    endcase
    return w;
  endfunction : resWord

  function automatic logic [7:0] resLen(input logic [2:0] code);
    logic [7:0] n;
    unique case (code)
      pans_pkg::RC_OK:        n = 8'h02;
      pans_pkg::RC_CONNECT:   n = 8'h07;
      pans_pkg::RC_RING:      n = 8'h04;
      pans_pkg::RC_NOCARRIER: n = 8'h0A;
      pans_pkg::RC_ERROR:     n = 8'h05;
      default:                n = 8'h00;
    endcase
    return n;
  endfunction : resLen

  // dial digits and modifiers that a slot may hold
  function automatic logic storable(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h44) ||
           c == 8'h2A || c == 8'h23 || c == 8'h2C || c == 8'h3B ||
           c == 8'h21 || c == 8'h40 || c == 8'h57 || c == 8'h54 ||
           c == 8'h50 || c == 8'h52 || c == pans_pkg::ASC_S;
  endfunction : storable

  // next state of the whole block
  always_comb
  begin
    logic       verbose;
    logic [7:0] pre, k, bodyLen, bodyCh, emCh, bk, ek;
    logic [1:0] e;
    logic       emEnd, emSkip, slotFree, post2, doStore;
    logic [7:0] c;
    logic [79:0] w;
    next_r   = r;
    actWe    = 1'b0;
    actAddr  = '0;
    actData  = '0;
    stoWe    = 1'b0;
    stoData  = '0;
    numWe    = 1'b0;
    lenWe    = 1'b0;
    scrWe    = 1'b0;
    scrAddr  = r.len;
    scrData  = '0;
    rselWe   = 1'b0;
    rselD    = 1'b0;
    doStore  = 1'b0;
    c        = rxIn.ch;
    verbose  = activeMem[pans_pkg::OPT_IDX][pans_pkg::OPT_VERBOSE_BIT];
    pre      = verbose ? 8'h02 : 8'h00;
    k        = r.idx - pre;
    w        = resWord(r.code);
    bodyCh   = '0;
    emCh     = '0;
    emEnd    = 1'b0;
    emSkip   = 1'b0;
    bk       = '0;
    bodyLen  = '0;
    post2    = 1'b0;
    ek       = '0;
    e        = '0;
    slotFree = !r.tx.valid || txReady;
    if (r.tx.valid && txReady)
      next_r.tx.valid = 1'b0;

    // synchronisers and internal transmit clock divider
    next_r.dteSync = {r.dteSync[0], dteTxClk};
    next_r.carSync = {r.carSync[0], carrierClk};
    if (r.div == 12'(pans_pkg::SYNC_HALF_CYC - 1))
    begin
      next_r.div    = '0;
      next_r.intClk = !r.intClk;
    end
    else
      next_r.div = r.div + 12'h001;
    next_r.txClkOut = r.intClk;
    if (activeMem[pans_pkg::OPT_IDX][1:0] == 2'd1 && pans_pkg::EXTERNAL_UNIT)
      next_r.txClkOut = r.dteSync[1];
    if (activeMem[pans_pkg::OPT_IDX][1:0] == 2'd2)
      next_r.txClkOut = r.carSync[1];
    if (!r.ctrl[pans_pkg::CTRL_SYNC_BIT])
      next_r.txClkOut = 1'b0;

    unique case (r.state)
      pans_pkg::ST_RESULT: bodyLen = verbose ? resLen(r.code) : 8'h01;
      pans_pkg::ST_LIST:   bodyLen = pans_pkg::LIST_LEN;
      default:             bodyLen = pans_pkg::BLIST_LEN;
    endcase
    post2 = verbose || r.state != pans_pkg::ST_RESULT;
    if (r.state == pans_pkg::ST_LIST)
      unique case (k[2:0])
        3'd0: bodyCh = pans_pkg::ASC_S;
        3'd1: bodyCh = pans_pkg::ASC_0 + {7'h00, k[6:3] > 4'd9};
        3'd2: bodyCh = decDigit({4'h0, k[6:3]}, 2'd0);
        3'd3: bodyCh = pans_pkg::ASC_COLON;
        3'd7: bodyCh = pans_pkg::ASC_SP;
        default: bodyCh = decDigit(activeMem[k[6:3]], 2'(3'd6 - k[2:0]));
      endcase
    else if (r.state == pans_pkg::ST_BLIST)
    begin
      // barred slots with attempts, then calls
      e  = 2'(k / 8'd6);
      ek = 8'(k % 8'd6);
      bk = k - pans_pkg::BL_ENTRIES;
      if (k < pans_pkg::BL_ENTRIES)
        unique case (ek)
          8'd0:    bodyCh = pans_pkg::ASC_0 + {6'h00, e};
          8'd1:    bodyCh = pans_pkg::ASC_COLON;
          8'd5:    bodyCh = pans_pkg::ASC_SP;
          default: bodyCh = decDigit(r.att[e], 2'(8'd4 - ek));
        endcase
      else
        unique case (bk)
          8'd0:    bodyCh = pans_pkg::ASC_C;
          8'd1:    bodyCh = pans_pkg::ASC_COLON;
          default: bodyCh = decDigit(r.blCalls, 2'(8'd4 - bk));
        endcase
      emSkip = k < pans_pkg::BL_ENTRIES && !r.barred[e];
    end
    else
      bodyCh = verbose ? w[79 - 8 * int'(k[3:0]) -: 8]
                       : pans_pkg::ASC_0 + {5'h00, r.code};
    if (verbose && r.idx < 8'h02)
      emCh = r.idx[0] ? pans_pkg::ASC_LF : pans_pkg::ASC_CR;
    else if (k < bodyLen)
      emCh = bodyCh;
    else if (k == bodyLen)
      emCh = pans_pkg::ASC_CR;
    else if (k == bodyLen + 8'h01 && post2)
      emCh = pans_pkg::ASC_LF;
    else
      emEnd = 1'b1;

    unique case (r.state)
      pans_pkg::ST_LOAD:
      begin
        // stored profile into active after reset
        actWe   = 1'b1;
        actAddr = r.idx[4:0];
        actData = storedMem[resetSel][r.idx[4:0]];
        if (r.idx[4:0] == pans_pkg::SER_IDX)
          next_r.serial = actData;
        next_r.idx = r.idx + 8'h01;
        if (r.idx == 8'(pans_pkg::PROF_BYTES - 1))
          next_r.state = pans_pkg::ST_IDLE;
      end
      pans_pkg::ST_STORE:
      begin
        // active profile into chosen stored profile
        stoWe   = 1'b1;
        stoData = activeMem[r.idx[4:0]];
        if (r.idx[4:0] == pans_pkg::SER_IDX)
          stoData = r.serial;
        next_r.idx = r.idx + 8'h01;
        // result only after the last byte
        if (r.idx == 8'(pans_pkg::PROF_BYTES - 1))
        begin
          next_r.state = pans_pkg::ST_RESULT;
          next_r.idx   = '0;
          next_r.code  = pans_pkg::RC_OK;
        end
      end
      pans_pkg::ST_FACT:
      begin
        // factory reload leaves reset selection alone
        actWe   = 1'b1;
        actAddr = r.idx[4:0];
        actData = (r.idx[4:0] == pans_pkg::OPT_IDX) ? pans_pkg::FACTORY_OPT
                                                     : pans_pkg::FACTORY_SREG;
        next_r.idx = r.idx + 8'h01;
        if (r.idx[4:0] == pans_pkg::OPT_IDX)
        begin
          next_r.state = pans_pkg::ST_RESULT;
          next_r.idx   = '0;
          next_r.code  = pans_pkg::RC_OK;
        end
      end
      pans_pkg::ST_NUMP:
        if (rxIn.valid)
        begin
          if (c == pans_pkg::ASC_CR)
          begin
            if (!r.locKnown)
              next_r.loc = 2'd0;
            next_r.idx   = '0;
            next_r.state = r.perr ? pans_pkg::ST_RESULT : pans_pkg::ST_NUMWR;
            next_r.code  = pans_pkg::RC_ERROR;
          end
          else if (!r.haveFirst && !r.locKnown)
          begin
            next_r.haveFirst = c != pans_pkg::ASC_EQ;
            next_r.locKnown  = c == pans_pkg::ASC_EQ;
            next_r.first     = c;
            doStore          = c != pans_pkg::ASC_EQ;
          end
          else if (!r.locKnown)
          begin
            next_r.locKnown = 1'b1;
            doStore         = c != pans_pkg::ASC_EQ;
            if (c == pans_pkg::ASC_EQ)
            begin
              // slot from the character before the delimiter
              next_r.len  = '0;
              next_r.loc  = r.first[1:0];
              next_r.perr = r.perr || r.first < pans_pkg::ASC_0 ||
                            r.first > pans_pkg::ASC_0 + 8'h03;
            end
          end
          else
            doStore = 1'b1;
        end
      pans_pkg::ST_NUMWR:
      begin
        // copy line into the addressed slot
        numWe      = 1'b1;
        next_r.idx = r.idx + 8'h01;
        if (r.idx == 8'(pans_pkg::NUM_CHARS - 1))
        begin
          // zero length marks the slot empty; its characters are still copied from the scratch line
          lenWe        = 1'b1;
          next_r.state = pans_pkg::ST_RESULT;
          next_r.idx   = '0;
          next_r.code  = pans_pkg::RC_OK;
        end
      end
      pans_pkg::ST_RESULT, pans_pkg::ST_LIST, pans_pkg::ST_BLIST:
        if (emEnd)
        begin
          next_r.idx   = '0;
          next_r.code  = pans_pkg::RC_OK;
          next_r.state = (r.state == pans_pkg::ST_RESULT) ?
                         pans_pkg::ST_IDLE : pans_pkg::ST_RESULT;
        end
        else if (emSkip)
          next_r.idx = r.idx + 8'h01;
        else if (slotFree)
        begin
          next_r.tx.valid = 1'b1;
          next_r.tx.ch    = emCh;
          next_r.idx      = r.idx + 8'h01;
        end
      default:
        if (bus.wr && bus.addr == pans_pkg::ADDR_CMD)
        begin
          next_r.idx  = '0;
          next_r.prof = bus.wdata[4];
          next_r.code = bus.wdata[6:4];
          unique case (bus.wdata[3:0])
            pans_pkg::OP_STORE_PROF: next_r.state = pans_pkg::ST_STORE;
            pans_pkg::OP_FACTORY:    next_r.state = pans_pkg::ST_FACT;
            pans_pkg::OP_LIST:       next_r.state = pans_pkg::ST_LIST;
            pans_pkg::OP_RESULT:     next_r.state = pans_pkg::ST_RESULT;
            pans_pkg::OP_SET_RSEL:
            begin
              // selection stored when the command runs
              rselWe       = 1'b1;
              rselD        = bus.wdata[4];
              next_r.state = pans_pkg::ST_RESULT;
              next_r.code  = pans_pkg::RC_OK;
            end
            pans_pkg::OP_NUMSTORE:
            begin
              next_r.state     = pans_pkg::ST_NUMP;
              next_r.haveFirst = 1'b0;
              next_r.locKnown  = 1'b0;
              next_r.loc       = '0;
              next_r.len       = '0;
              next_r.perr      = 1'b0;
            end
            pans_pkg::OP_BLIST:
            begin
              next_r.state = pans_pkg::ST_RESULT;
              next_r.code  = pans_pkg::RC_ERROR;
              if (r.ctrl[pans_pkg::CTRL_BLACK_BIT])
                next_r.state = pans_pkg::ST_BLIST;
            end
            default: next_r.idx = r.idx;
          endcase
        end
    endcase

    // dial character filter and refusals
    if (doStore)
    begin
      // refused modifiers turn into an error
      if (c == pans_pkg::ASC_S || (c == pans_pkg::ASC_SEMI &&
          r.ctrl[pans_pkg::CTRL_SMODE2_BIT]))
        next_r.perr = 1'b1;
      else if (storable(c) && r.len < 6'(pans_pkg::NUM_CHARS))
      begin
        scrWe      = 1'b1;
        scrAddr    = next_r.len;
        scrData    = c;
        next_r.len = next_r.len + 6'h01;
      end
    end
    if (next_r.state == pans_pkg::ST_RESULT && r.state != pans_pkg::ST_RESULT)
      next_r.lastErr = next_r.code == pans_pkg::RC_ERROR;

    // register writes
    if (bus.wr)
      unique case (bus.addr)
        pans_pkg::ADDR_SIDX:    next_r.sIdx    = bus.wdata[3:0];
        pans_pkg::ADDR_SERIAL:  next_r.serial  = bus.wdata;
        pans_pkg::ADDR_CTRL:    next_r.ctrl    = bus.wdata[2:0];
        pans_pkg::ADDR_BLCALLS: next_r.blCalls = bus.wdata;
        pans_pkg::ADDR_BARRED:  next_r.barred  = bus.wdata[3:0];
        pans_pkg::ADDR_SDATA, pans_pkg::ADDR_OPT:
          if (r.state == pans_pkg::ST_IDLE)
          begin
            actWe   = 1'b1;
            actData = bus.wdata;
            actAddr = (bus.addr == pans_pkg::ADDR_OPT) ? pans_pkg::OPT_IDX
                                                       : {1'b0, r.sIdx};
          end
        default:
          if (bus.addr >= pans_pkg::ADDR_ATT0 &&
              bus.addr <= pans_pkg::ADDR_ATT3)
            next_r.att[bus.addr[1:0] - 2'd2] = bus.wdata;
      endcase

    // register reads, data valid one cycle later only
    next_r.rdata = '0;
    if (bus.rd)
      unique case (bus.addr)
        pans_pkg::ADDR_STATUS:
          next_r.rdata = {6'h00, r.lastErr, r.state != pans_pkg::ST_IDLE};
        pans_pkg::ADDR_SIDX:    next_r.rdata = {4'h0, r.sIdx};
        pans_pkg::ADDR_SDATA:   next_r.rdata = activeMem[{1'b0, r.sIdx}];
        pans_pkg::ADDR_OPT:     next_r.rdata = activeMem[pans_pkg::OPT_IDX];
        pans_pkg::ADDR_SERIAL:  next_r.rdata = r.serial;
        pans_pkg::ADDR_CTRL:    next_r.rdata = {5'h00, r.ctrl};
        pans_pkg::ADDR_RSEL:    next_r.rdata = {7'h00, resetSel};
        pans_pkg::ADDR_BLCALLS: next_r.rdata = r.blCalls;
        pans_pkg::ADDR_BARRED:  next_r.rdata = {4'h0, r.barred};
        pans_pkg::ADDR_NUMLEN:  next_r.rdata = {2'h0, numLen[r.sIdx[1:0]]};
        default:
          if (bus.addr >= pans_pkg::ADDR_ATT0 &&
              bus.addr <= pans_pkg::ADDR_ATT3)
            next_r.rdata = r.att[bus.addr[1:0] - 2'd2];
      endcase
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      r <= pans_pkg::REGS_RESET;
    else
      r <= next_r;
  end

  // memories keep their contents through reset
  always_ff @(posedge sys_clk)
  begin
    if (actWe)
      activeMem[actAddr] <= actData;
    if (stoWe)
      storedMem[r.prof][r.idx[4:0]] <= stoData;
    if (numWe)
      numMem[r.loc][r.idx[5:0]] <= scratch[r.idx[5:0]];
    if (lenWe)
      numLen[r.loc] <= r.len;
    if (scrWe)
      scratch[scrAddr] <= scrData;
    if (rselWe)
      resetSel <= rselD;
  end

  assign rdata    = r.rdata;
  assign txOut    = r.tx;
  assign txClkOut = r.txClkOut;

endmodule : profile_and_number_store

// >>> hdl/pans_pkg.sv
package pans_pkg;

  // profile image layout: S-registers, option byte, serial speed/parity
  localparam int         S_COUNT         = 16;
  localparam int         PROF_BYTES      = 18;
  localparam logic [4:0] OPT_IDX         = 5'h10;
  localparam logic [4:0] SER_IDX         = 5'h11;
  localparam int         NUM_SLOTS       = 4;
  localparam int         NUM_CHARS       = 36;
  localparam int         OPT_CLKSRC_LSB  = 0;
  localparam int         OPT_VERBOSE_BIT = 2;
  localparam int         CTRL_SYNC_BIT   = 0;
  localparam int         CTRL_SMODE2_BIT = 1;
  localparam int         CTRL_BLACK_BIT  = 2;
  localparam logic       EXTERNAL_UNIT   = 1'b1;

  // register offsets
  localparam logic [3:0] ADDR_CMD     = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_SIDX    = 4'h2;
  localparam logic [3:0] ADDR_SDATA   = 4'h3;
  localparam logic [3:0] ADDR_OPT     = 4'h4;
  localparam logic [3:0] ADDR_SERIAL  = 4'h5;
  localparam logic [3:0] ADDR_CTRL    = 4'h6;
  localparam logic [3:0] ADDR_RSEL    = 4'h7;
  localparam logic [3:0] ADDR_BLCALLS = 4'h8;
  localparam logic [3:0] ADDR_BARRED  = 4'h9;
  localparam logic [3:0] ADDR_ATT0    = 4'hA;
  localparam logic [3:0] ADDR_ATT3    = 4'hD;
  localparam logic [3:0] ADDR_NUMLEN  = 4'hE;

  // factory values
  localparam logic [7:0] FACTORY_SREG = 8'h00;
  localparam logic [7:0] FACTORY_OPT  = 8'h04;

  // command opcodes
  localparam logic [3:0] OP_STORE_PROF = 4'h1;
  localparam logic [3:0] OP_SET_RSEL   = 4'h2;
  localparam logic [3:0] OP_FACTORY    = 4'h3;
  localparam logic [3:0] OP_NUMSTORE   = 4'h4;
  localparam logic [3:0] OP_LIST       = 4'h5;
  localparam logic [3:0] OP_BLIST      = 4'h6;
  localparam logic [3:0] OP_RESULT     = 4'h7;

  // result codes
  localparam logic [2:0] RC_OK        = 3'h0;
  localparam logic [2:0] RC_CONNECT   = 3'h1;
  localparam logic [2:0] RC_RING      = 3'h2;
  localparam logic [2:0] RC_NOCARRIER = 3'h3;
  localparam logic [2:0] RC_ERROR     = 3'h4;

  // listing body lengths in characters
  localparam logic [7:0] LIST_LEN   = 8'h80;
  localparam logic [7:0] BL_ENTRIES = 8'h18;
  localparam logic [7:0] BLIST_LEN  = 8'h1D;

  // sync transmit clock from the internal divider
  localparam int SYS_CLK_HZ    = 40_000_000;
  localparam int SYNC_CLK_HZ   = 9600;
  localparam int SYNC_HALF_CYC = SYS_CLK_HZ / (2 * SYNC_CLK_HZ);

  // characters
  localparam logic [7:0] ASC_CR    = 8'h0D;
  localparam logic [7:0] ASC_LF    = 8'h0A;
  localparam logic [7:0] ASC_0     = 8'h30;
  localparam logic [7:0] ASC_EQ    = 8'h3D;
  localparam logic [7:0] ASC_SEMI  = 8'h3B;
  localparam logic [7:0] ASC_S     = 8'h53;
  localparam logic [7:0] ASC_C     = 8'h43;
  localparam logic [7:0] ASC_COLON = 8'h3A;
  localparam logic [7:0] ASC_SP    = 8'h20;

  typedef enum logic [3:0] {
    ST_LOAD   = 4'h0,
    ST_IDLE   = 4'h1,
    ST_NUMP   = 4'h3,
    ST_NUMWR  = 4'h2,
    ST_RESULT = 4'h6,
    ST_STORE  = 4'h7,
    ST_FACT   = 4'h5,
    ST_LIST   = 4'h4,
    ST_BLIST  = 4'hC
  } pans_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pans_bus_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] ch;
  } pans_char_type;

  typedef struct packed {
    pans_state_type  state;
    logic [7:0]      idx;
    logic [2:0]      code;
    logic            prof;
    logic            lastErr;
    logic [2:0]      ctrl;
    logic [7:0]      serial;
    logic [3:0]      sIdx;
    logic [7:0]      blCalls;
    logic [3:0]      barred;
    logic [3:0][7:0] att;
    logic            haveFirst;
    logic            locKnown;
    logic [7:0]      first;
    logic [1:0]      loc;
    logic [5:0]      len;
    logic            perr;
    logic [7:0]      rdata;
    pans_char_type   tx;
    logic [1:0]      dteSync;
    logic [1:0]      carSync;
    logic [11:0]     div;
    logic            intClk;
    logic            txClkOut;
  } pans_regs_type;

  localparam pans_regs_type REGS_RESET = '0;

endpackage : pans_pkg

// >>> sim/pans_chk.sv
`timescale 1ns/1ps
module pans_chk
(
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  // register port
  input wire pans_pkg::pans_bus_type  bus,
  input wire logic [7:0]              rdata,
  // terminal side
  input wire pans_pkg::pans_char_type rxIn,
  input wire pans_pkg::pans_char_type txOut,
  input wire logic                    txReady,
  // sync clock pins
  input wire logic                    dteTxClk,
  input wire logic                    carrierClk,
  input wire logic                    txClkOut
);
  logic       syncOn;
  logic [2:0] src;
  // shadow of sync mode and clock source, src[2] marks it known
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || (bus.wr && bus.addr == 4'h0 && bus.wdata[3:0] == 4'h3))
      src <= 3'h0;
    else if (bus.wr && bus.addr == 4'h4)
      src <= {1'b1, bus.wdata[1:0]};
    if (!rstn)
      syncOn <= 1'b0;
    else if (bus.wr && bus.addr == 4'h6)
      syncOn <= bus.wdata[0];
  end
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // bus and terminal handshake, sync transmit clock source and echo
  AST_RESET_QUIET: assert property (disable iff (1'b0) !rstn |=>
    !txOut.valid && !txClkOut && rdata == 8'h00) else $error("not quiet");
  AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  AST_UNMAPPED: assert property (bus.rd && bus.addr == 4'hF |=> rdata == 0)
    else $error("unmapped read not zero");
  AST_TX_HOLD: assert property (txOut.valid && !txReady |=>
    txOut.valid && $stable(txOut.ch)) else $error("character not held");
  AST_ECHO_RISE: assert property (
    syncOn && src == 3'h5 && $rose(dteTxClk) |-> ##[1:5] txClkOut)
    else $error("terminal clock rise not echoed");
  AST_ECHO_FALL: assert property (
    syncOn && src == 3'h5 && $fell(dteTxClk) |-> ##[1:5] !txClkOut)
    else $error("terminal clock fall not echoed");
  AST_CARRIER: assert property (
    syncOn && src == 3'h6 && $rose(carrierClk) |-> ##[1:5] txClkOut)
    else $error("carrier clock not passed on");
  AST_SYNC_OFF: assert property (!syncOn ##1 !syncOn |-> !txClkOut)
    else $error("transmit clock runs with sync off");
  // main scenarios
  COV_STALL: cover property (txOut.valid && !txReady ##1 txReady);
  COV_READ: cover property (bus.rd ##1 rdata != 8'h00);
  COV_ECHO: cover property (syncOn && src == 3'h5 && $rose(txClkOut));
endmodule : pans_chk

// >>> sim/pans_host.sv
`timescale 1ns/1ps
module pans_host
(
  // clock
  input wire logic                    sys_clk,
  // characters to and from the block
  input wire pans_pkg::pans_char_type txOut,
  output pans_pkg::pans_char_type     rxIn,
  output logic                        txReady
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  initial
    rxIn = '0;
  initial
    txReady = 1'b1;
  // take characters, stalling every other cycle when slow
  always @(posedge sys_clk)
  begin
    if (txOut.valid && txReady)
      got.push_back(txOut.ch);
    txReady <= !slow || !txReady;
  end
  // send one line; the character field is scrambled between strobes
  task automatic send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      rxIn <= '{1'b1, (i < s.len()) ? s[i] : pans_pkg::ASC_CR};
      @(posedge sys_clk);
      rxIn <= '{1'b0, ~rxIn.ch};
      @(posedge sys_clk);
    end
  endtask : send
endmodule : pans_host

// >>> sim/profile_and_number_store_tb.sv
`timescale 1ns/1ps
module profile_and_number_store_tb;
  logic                    sys_clk;
  logic                    rstn;
  pans_pkg::pans_bus_type  bus;
  logic [7:0]              rdata;
  logic [7:0]              last;
  pans_pkg::pans_char_type rxIn;
  pans_pkg::pans_char_type txOut;
  logic                    txReady;
  logic                    dteTxClk;
  logic                    carrierClk;
  logic                    txClkOut;
  int                      n_errors;
  int                      n_checks;
  int                      edges;
  string                   body;
  string                   word[5] = '{"OK", "CONNECT", "RING", "NO CARRIER",
    "ERROR"};
  string                   lines[10] = '{"1=3456H;AX", "5=12", "789", "2=9",
    "2=", "=44", "0=1111111111111111111111111111111111111111", "3=S5", "1=5;",
    "S=7"};
  int                      code[10] = '{0, 4, 0, 0, 0, 0, 0, 4, 4, 4};
  int                      slot[10] = '{1, 1, 0, 2, 2, 0, 0, 1, 1, 1};
  int                      len[10] = '{6, 6, 3, 1, 0, 2, 36, 6, 6, 6};
  // design and terminal model
  profile_and_number_store dut (.sys_clk(sys_clk), .rstn(rstn), .bus(bus),
    .rdata(rdata), .rxIn(rxIn), .txOut(txOut), .txReady(txReady),
    .dteTxClk(dteTxClk), .carrierClk(carrierClk), .txClkOut(txClkOut));
  pans_host host (.sys_clk(sys_clk), .txOut(txOut), .rxIn(rxIn),
    .txReady(txReady));
  // clock and transmit clock edge counter
  initial
  begin
    sys_clk = 1'b0;
    forever
      #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge txClkOut)
    edges++;
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic stop();
    n_errors++;
    results();
  endtask : stop
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] v);
    n_checks++;
    if (v !== e)
      $display("Error %s expected %h seen %h", what, e, v);
    if (v !== e)
      n_errors++;
  endtask : chk
  // one bus cycle then a quiet cycle, read data kept in last
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    bus <= '{a, d, w, !w};
    @(posedge sys_clk);
    bus <= '0;
    #1 last = rdata;
    @(posedge sys_clk);
  endtask : acc
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, last);
  endtask : rd
  task automatic idle();
    last = 8'h01;
    for (int i = 0; i < 600 && last[0] !== 1'b0; i++)
      acc(1'b0, 4'h1, 8'h00);
    if (last[0] !== 1'b0)
      stop();
  endtask : idle
  task automatic expTx(input string e);
    for (int i = 0; i < 3000 && host.got.size() < e.len(); i++)
      @(posedge sys_clk);
    if (host.got.size() < e.len())
      stop();
    for (int i = 0; i < e.len(); i++)
      chk("txOut.ch", e[i], host.got[i]);
    host.got.delete();
  endtask : expTx
  task automatic cmd(input logic [7:0] c, input string e);
    acc(1'b1, 4'h0, c);
    expTx(e);
    idle();
  endtask : cmd
  task automatic rst(input int n);
    rstn <= 1'b0;
    repeat (n)
      @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    idle();
    host.got.delete();
  endtask : rst
  // main sequence
  initial
  begin
    bus = '0;
    rstn = 1'b0;
    dteTxClk = 1'b0;
    carrierClk = 1'b0;
    rst(12);
    cmd(8'h03, "\r\nOK\r\n");
    rd(4'h4, 8'h04);
    acc(1'b1, 4'h2, 8'h05);
    acc(1'b1, 4'h3, 8'h2A);
    acc(1'b1, 4'h5, 8'h3C);
    cmd(8'h11, "\r\nOK\r\n");
    acc(1'b1, 4'h3, 8'h11);
    acc(1'b1, 4'h5, 8'h00);
    cmd(8'h12, "\r\nOK\r\n");
    cmd(8'h03, "\r\nOK\r\n");
    rd(4'h7, 8'h01);
    rst(3);
    acc(1'b1, 4'h2, 8'h05);
    rd(4'h3, 8'h2A);
    rd(4'h5, 8'h3C);
    body = "\r\n";
    for (int j = 0; j < 16; j++)
      body = {body, $sformatf("S%02d:%03d ", j, (j == 5) ? 42 : 0)};
    host.slow = 1'b1;
    acc(1'b1, 4'h0, 8'h05);
    host.send("1=9");
    expTx({body, "\r\n\r\nOK\r\n"});
    host.slow = 1'b0;
    idle();
    for (int c = 0; c < 5; c++)
      cmd({c[3:0], 4'h7}, {"\r\n", word[c], "\r\n"});
    rd(4'h1, 8'h02);
    acc(1'b1, 4'h4, 8'h00);
    cmd(8'h37, "3\r");
    for (int i = 0; i < 10; i++)
    begin
      acc(1'b1, 4'h6, (i == 8) ? 8'h03 : 8'h00);
      acc(1'b1, 4'h0, 8'h04);
      host.send(lines[i]);
      expTx($sformatf("%0d\r", code[i]));
      idle();
      acc(1'b1, 4'h2, slot[i][7:0]);
      rd(4'hE, len[i][7:0]);
    end
    cmd(8'h06, "4\r");
    acc(1'b1, 4'h6, 8'h04);
    acc(1'b1, 4'h9, 8'h02);
    acc(1'b1, 4'hB, 8'h07);
    acc(1'b1, 4'h8, 8'h0C);
    cmd(8'h06, "1:007 C:012\r\n0\r");
    acc(1'b1, 4'h4, 8'h01);
    acc(1'b1, 4'h6, 8'h01);
    for (int s = 1; s < 4; s++)
    begin
      acc(1'b1, 4'h4, (s == 3) ? 8'h00 : s[7:0]);
      repeat (4)
        @(posedge sys_clk);
      edges = 0;
      for (int k = 0; k < ((s == 3) ? 1 : 8); k++)
      begin
        repeat ((s == 3) ? 8322 : 10)
          @(posedge sys_clk);
        if (s == 1)
          dteTxClk <= !dteTxClk;
        if (s == 2)
          carrierClk <= !carrierClk;
      end
      repeat (10)
        @(posedge sys_clk);
      chk("txClkOut rises", (s == 3) ? 8'h02 : 8'h04, edges[7:0]);
    end
    acc(1'b1, 4'h6, 8'h00);
    rd(4'hF, 8'h00);
    results();
  end
endmodule : profile_and_number_store_tb
bind profile_and_number_store pans_chk chk (.sys_clk(sys_clk), .rstn(rstn),
  .bus(bus), .rdata(rdata), .rxIn(rxIn), .txOut(txOut), .txReady(txReady),
  .dteTxClk(dteTxClk), .carrierClk(carrierClk), .txClkOut(txClkOut));
